/* wwm_host.sv */
`timescale 1ns/1ps
`default_nettype none

module wwm_host (
  input  wire logic clk,
  output var  logic service
);
  initial service = 1'b1;
  // back-to-back calls put falls one gap apart; the line idles high
  task automatic pulse(input int us);
    repeat (us * 125 - 20) @(posedge clk);
    service <= 1'b0;
    repeat (20) @(posedge clk);
    service <= 1'b1;
  endtask
endmodule // wwm_host

`default_nettype wire

/* wwm_pkg.sv */
package wwm_pkg;

  // timebase: one tick per microsecond of elapsed time
  localparam int CLK_PERIOD_PS = 8000;
  localparam int US_PS         = 1000000;
  localparam int TICK_CYCLES   = (US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TICK_W        = $clog2(TICK_CYCLES);

  // elapsed time in microseconds, wide enough for the longest window
  localparam int ELAPSED_W     = 22;

  // factory window bounds, microseconds
  localparam logic [ELAPSED_W-1:0] SEL00_LOWER_US = 22'h00652c; // 25.9 ms
  localparam logic [ELAPSED_W-1:0] SEL00_UPPER_US = 22'h00b6d0; // 46.8 ms
  localparam logic [ELAPSED_W-1:0] SEL01_LOWER_US = 22'h0186a0; // 100 ms
  localparam logic [ELAPSED_W-1:0] SEL01_UPPER_US = 22'h030d40; // 200 ms
  localparam logic [ELAPSED_W-1:0] SEL10_LOWER_US = 22'h061a80; // 400 ms
  localparam logic [ELAPSED_W-1:0] SEL10_UPPER_US = 22'h0c3500; // 800 ms
  localparam logic [ELAPSED_W-1:0] SEL11_LOWER_US = 22'h0c3500; // 800 ms
  localparam logic [ELAPSED_W-1:0] SEL11_UPPER_US = 22'h186a00; // 1.6 s

  // window used when a capacitor sits on the window pin
  localparam logic [ELAPSED_W-1:0] CAP_LOWER_US   = 22'h002710; // 10 ms
  localparam logic [ELAPSED_W-1:0] CAP_UPPER_US   = 22'h004e20; // 20 ms

  // fault hold time with the delay pin floating
  localparam logic [ELAPSED_W-1:0] RESET_DELAY_US = 22'h030d40; // 200 ms

  typedef enum logic [1:0] {
    WWM_ST_RUN   = 2'b00,
    WWM_ST_FAULT = 2'b01
  } wwm_state_t;

endpackage

/* wwm_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module wwm_sva #(
  parameter int LO   = 20,
  parameter int UP   = 50,
  parameter int HOLD = 30
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic service_pulse_in,
  input wire logic window_select_0,
  input wire logic window_select_1,
  input wire logic window_cap_pin,
  input wire logic reset_delay_cap_pin,
  input wire logic fault_out_n_out,
  input wire logic fault_out_n_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // only the both-selects-high factory window is modelled here
  wire cfg = window_select_0 & window_select_1 & window_cap_pin;
  int  quiet;
  int  low;
  always_ff @(posedge clk) begin
    quiet <= (!resetn || !fault_out_n_oe_n || $fell(service_pulse_in)) ? 0 : quiet + 1;
    low   <= (!resetn || fault_out_n_oe_n) ? 0 : low + 1;
  end
  a_reset_release: assert property (disable iff (1'b0) !resetn |=> fault_out_n_oe_n)
    else $error("fault pin pulled during reset");
  a_out_data_low: assert property (fault_out_n_out == 1'b0)
    else $error("fault pin data not low");
  a_early_edge_fault: assert property ($fell(service_pulse_in) && fault_out_n_oe_n && cfg
    && quiet > 8 && quiet < LO * 125 - 8 |-> ##[1:6] !fault_out_n_oe_n)
    else $error("early service edge not faulted");
  a_timeout_fault: assert property (fault_out_n_oe_n && cfg |-> quiet < (UP + 2) * 125)
    else $error("missing service edge not faulted");
  a_valid_edge_ok: assert property ($fell(service_pulse_in) && fault_out_n_oe_n && cfg
    && quiet > LO * 125 + 260 && quiet < UP * 125 - 260 |=> fault_out_n_oe_n [*6])
    else $error("valid service edge faulted");
  a_hold_min: assert property ($rose(fault_out_n_oe_n) |-> low >= (HOLD - 1) * 125)
    else $error("fault released too soon");
  a_hold_max: assert property (reset_delay_cap_pin |-> low < (HOLD + 2) * 125)
    else $error("fault held too long");
  a_latch_keep: assert property ((!reset_delay_cap_pin) [*4] ##0 !fault_out_n_oe_n
    |=> !fault_out_n_oe_n)
    else $error("latched fault released");
  c_early: cover property ($fell(service_pulse_in) && cfg && quiet < LO * 125 - 8);
  c_valid: cover property ($fell(service_pulse_in) && cfg && quiet > LO * 125 + 260);
  c_timeout: cover property (cfg && quiet == UP * 125);
endmodule // wwm_sva

bind wwm_window_watchdog_monitor wwm_sva #(.LO(P_SEL11_LOWER_US), .UP(P_SEL11_UPPER_US),
  .HOLD(P_RESET_DELAY_US)) u_sva (.clk(clk), .resetn(resetn),
  .service_pulse_in(service_pulse_in), .window_select_0(window_select_0),
  .window_select_1(window_select_1), .window_cap_pin(window_cap_pin),
  .reset_delay_cap_pin(reset_delay_cap_pin), .fault_out_n_out(fault_out_n_out),
  .fault_out_n_oe_n(fault_out_n_oe_n));

`default_nettype wire

/* wwm_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module wwm_timer
  import wwm_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   resetn,
  wwm_timer_if.timer  tm
);

  localparam logic [TICK_W-1:0]    TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [ELAPSED_W-1:0] SAT       = '1;

  logic [TICK_W-1:0]    pre;
  logic [ELAPSED_W-1:0] elapsed;

  wire                  tick         = (pre == TICK_LAST);
  wire [TICK_W-1:0]     next_pre     = tick ? '0 : pre + TICK_W'(1);
  // saturate so a silent host never wraps back into the open window
  wire [ELAPSED_W-1:0]  next_elapsed = (tick && elapsed != SAT) ? elapsed + ELAPSED_W'(1)
                                                                 : elapsed;

  always_ff @(posedge clk) begin
    if (!resetn || tm.restart) begin
      pre     <= '0;
      elapsed <= '0;
    end else begin
      pre     <= next_pre;
      elapsed <= next_elapsed;
    end
  end

  assign tm.elapsed = elapsed;

endmodule // wwm_timer

`default_nettype wire

/* wwm_timer_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface wwm_timer_if #(
  parameter int W = 22
);
  logic         restart;
  logic [W-1:0] elapsed;

  modport timer (
    input  restart,
    output elapsed
  );
  modport user (
    output restart,
    input  elapsed
  );
endinterface

`default_nettype wire

/* wwm_window_watchdog_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module wwm_window_watchdog_monitor
  import wwm_pkg::*;
#(
  parameter logic [ELAPSED_W-1:0] P_SEL00_LOWER_US = SEL00_LOWER_US,
  parameter logic [ELAPSED_W-1:0] P_SEL00_UPPER_US = SEL00_UPPER_US,
  parameter logic [ELAPSED_W-1:0] P_SEL01_LOWER_US = SEL01_LOWER_US,
  parameter logic [ELAPSED_W-1:0] P_SEL01_UPPER_US = SEL01_UPPER_US,
  parameter logic [ELAPSED_W-1:0] P_SEL10_LOWER_US = SEL10_LOWER_US,
  parameter logic [ELAPSED_W-1:0] P_SEL10_UPPER_US = SEL10_UPPER_US,
  parameter logic [ELAPSED_W-1:0] P_SEL11_LOWER_US = SEL11_LOWER_US,
  parameter logic [ELAPSED_W-1:0] P_SEL11_UPPER_US = SEL11_UPPER_US,
  parameter logic [ELAPSED_W-1:0] P_CAP_LOWER_US   = CAP_LOWER_US,
  parameter logic [ELAPSED_W-1:0] P_CAP_UPPER_US   = CAP_UPPER_US,
  parameter logic [ELAPSED_W-1:0] P_RESET_DELAY_US = RESET_DELAY_US
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic service_pulse_in,
  input  wire logic window_select_0,
  input  wire logic window_select_1,
  input  wire logic window_cap_pin,
  input  wire logic reset_delay_cap_pin,
  input  wire logic fault_out_n_in,
  output var  logic fault_out_n_out,
  output var  logic fault_out_n_oe_n
);

  localparam int NSYNC = 6;
  localparam int I_SVC = 0;
  localparam int I_S0  = 1;
  localparam int I_S1  = 2;
  localparam int I_CAP = 3;
  localparam int I_DLY = 4;
  localparam int I_PIN = 5;

  // every pin crosses two flops before any logic looks at it
  wire  [NSYNC-1:0] pins_raw = {fault_out_n_in, reset_delay_cap_pin, window_cap_pin,
                                window_select_1, window_select_0, service_pulse_in};
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic             svc_prev;

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!resetn) begin
          sync_a[g] <= 1'b1;
          sync_b[g] <= 1'b1;
        end else begin
          sync_a[g] <= pins_raw[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!resetn) begin
      svc_prev <= 1'b1;
    end else begin
      svc_prev <= sync_b[I_SVC];
    end
  end

  // window bound lookup; a floating capacitor pin reads high
  function automatic logic [ELAPSED_W-1:0] bound_of(input logic cap_float,
                                                    input logic [1:0] sel,
                                                    input logic upper);
    logic [ELAPSED_W-1:0] b;
    b = '0;
    if (!cap_float) begin
      b = upper ? P_CAP_UPPER_US : P_CAP_LOWER_US;
    end else begin
      case (sel)
        2'b00:   b = upper ? P_SEL00_UPPER_US : P_SEL00_LOWER_US;
        2'b01:   b = upper ? P_SEL01_UPPER_US : P_SEL01_LOWER_US;
        2'b10:   b = upper ? P_SEL10_UPPER_US : P_SEL10_LOWER_US;
        default: b = upper ? P_SEL11_UPPER_US : P_SEL11_LOWER_US;
      endcase
    end
    return b;
  endfunction

  wwm_timer_if #(.W(ELAPSED_W)) tmr ();

  wwm_timer u_timer (
    .clk    (clk),
    .resetn (resetn),
    .tm     (tmr.timer)
  );

  wire [1:0]           sel_now     = {sync_b[I_S1], sync_b[I_S0]};
  wire [ELAPSED_W-1:0] lower_bound = bound_of(sync_b[I_CAP], sel_now, 1'b0);
  wire [ELAPSED_W-1:0] upper_bound = bound_of(sync_b[I_CAP], sel_now, 1'b1);

  wwm_state_t state;
  wwm_state_t next_state;
  logic       restart;
  logic       next_restart;

  // the timer still shows the old count while a restart is in flight
  wire settled       = !restart;
  wire svc_fall      = svc_prev && !sync_b[I_SVC];
  wire too_early     = settled && svc_fall && (tmr.elapsed < lower_bound);
  wire timed_out     = settled && (tmr.elapsed >= upper_bound);
  wire valid_edge    = settled && svc_fall && !too_early && !timed_out;
  wire delay_done    = settled && (tmr.elapsed >= P_RESET_DELAY_US);
  // external feedback holding the delay pin low latches the fault; only reset clears it
  wire latched       = !sync_b[I_DLY];
  // the wire cannot read back high while this device pulls it, so the hold ends by
  // letting go of the pin first; the fault is left only once the pull-up has brought
  // the line back, so a wire that something else still holds low keeps the fault
  wire hold_done     = (state == WWM_ST_FAULT) && delay_done && !latched;
  wire release_fault = hold_done && sync_b[I_PIN];

  always_comb begin
    next_state   = state;
    next_restart = 1'b0;
    case (state)
      WWM_ST_RUN: begin
        if (too_early || timed_out) begin
          next_state   = WWM_ST_FAULT;
          next_restart = 1'b1;
        end else if (valid_edge) begin
          next_restart = 1'b1;
        end
      end
      WWM_ST_FAULT: begin
        if (release_fault) begin
          next_state   = WWM_ST_RUN;
          next_restart = 1'b1;
        end
      end
      default: begin
        next_state   = WWM_ST_FAULT;
        next_restart = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state   <= WWM_ST_RUN;
      restart <= 1'b1;
    end else begin
      state   <= next_state;
      restart <= next_restart;
    end
  end

  assign tmr.restart = restart;

  // pull low from the cycle a fault is taken until the hold is over
  wire next_drive = (next_state == WWM_ST_FAULT) && !hold_done;

  // open drain: the data bit is always low, only the enable moves
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fault_out_n_out  <= 1'b0;
      fault_out_n_oe_n <= 1'b1;
    end else begin
      fault_out_n_out  <= 1'b0;
      fault_out_n_oe_n <= !next_drive;
    end
  end

endmodule // wwm_window_watchdog_monitor

`default_nettype wire

/* wwm_window_watchdog_monitor_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end

module wwm_window_watchdog_monitor_tb;
  import wwm_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cap = 1'b1;
  logic fb_off = 1'b1;
  logic [1:0] sel = 2'b11;
  wire  service;
  wire  out;
  wire  oe_n;
  // open-drain wire: pulled up unless the device pulls it
  wire  lvl = oe_n ? 1'b1 : 1'b0;
  // latching use: an external buffer copies the fault wire onto the delay pin
  wire  dly = fb_off | lvl;
  int   fail_count = 0;
  int   total_checks = 0;
  int   n;
  initial forever #4 clk = ~clk;
  wwm_host host (.clk(clk), .service(service));
  wwm_window_watchdog_monitor #(.P_SEL00_LOWER_US(22'h00000c), .P_SEL00_UPPER_US(22'h000018),
    .P_SEL01_LOWER_US(22'h000010), .P_SEL01_UPPER_US(22'h000020),
    .P_SEL10_LOWER_US(22'h000018), .P_SEL10_UPPER_US(22'h000028),
    .P_SEL11_LOWER_US(22'h000014), .P_SEL11_UPPER_US(22'h000032),
    .P_CAP_LOWER_US(22'h00000a), .P_CAP_UPPER_US(22'h000014), .P_RESET_DELAY_US(22'h00001e))
    dut (.clk(clk), .resetn(resetn), .service_pulse_in(service), .window_select_0(sel[0]),
    .window_select_1(sel[1]), .window_cap_pin(cap), .reset_delay_cap_pin(dly),
    .fault_out_n_in(lvl), .fault_out_n_out(out), .fault_out_n_oe_n(oe_n));
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset(input logic c, input logic d, input logic [1:0] s);
    @(posedge clk);
    cap <= c;
    fb_off <= d;
    sel <= s;
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    #1;
    `CHK("oe_n", 1'b1, oe_n)
    `CHK("out", 1'b0, out)
  endtask
  task automatic wait_oe(input logic v, input int lim, output int k);
    k = 0;
    while (oe_n !== v && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= lim) begin
      fail_count++;
      end_of_test();
    end
  endtask
  task automatic s_valid_then_early();
    do_reset(1'b1, 1'b1, 2'b11);
    repeat (3) begin
      host.pulse(35);
      repeat (10) @(posedge clk);
      #1;
      `CHK("valid", 1'b1, oe_n)
    end
    host.pulse(10);
    wait_oe(1'b0, 40, n);
    wait_oe(1'b1, 4000, n);
    `CHK("hold", 1'b1, n >= 3625 && n <= 3885)
    wait_oe(1'b0, 7000, n);
    `CHK("timeout", 1'b1, n >= 6125 && n <= 6385)
  endtask
  task automatic s_latch();
    do_reset(1'b1, 1'b0, 2'b11);
    wait_oe(1'b0, 7000, n);
    repeat (8000) @(posedge clk);
    #1;
    `CHK("latch", 1'b0, oe_n)
  endtask
  task automatic s_cap_window();
    do_reset(1'b0, 1'b1, 2'b11);
    host.pulse(15);
    repeat (10) @(posedge clk);
    #1;
    `CHK("cap valid", 1'b1, oe_n)
    host.pulse(5);
    wait_oe(1'b0, 40, n);
    `CHK("cap early", 1'b0, oe_n)
  endtask
  // mid-window edge must pass, an edge four microseconds short of lower must fault
  task automatic s_select(input logic [1:0] s, input int lo, input int up);
    do_reset(1'b1, 1'b1, s);
    host.pulse((lo + up) / 2);
    repeat (10) @(posedge clk);
    #1;
    `CHK("sel valid", 1'b1, oe_n)
    host.pulse(lo - 4);
    wait_oe(1'b0, 40, n);
    `CHK("sel early", 1'b0, oe_n)
  endtask
  initial begin
    s_valid_then_early();
    s_latch();
    s_cap_window();
    s_select(2'b00, 12, 24);
    s_select(2'b01, 16, 32);
    s_select(2'b10, 24, 40);
    end_of_test();
  end
endmodule // wwm_window_watchdog_monitor_tb

`default_nettype wire
